//--- rtl/hbfs_pkg.sv
// constants, types and fault-handling outline for the half-bridge supervisor
// What this block does
// - stopped pwm with freewheel: high off, low on
// - low-current open-load mode on first two highs
// - overcurrent filter expiry latches switch off, flags
// - overcurrent or open-load sets global load fault
// - per-switch overcurrent and open-load flag banks
// - tripped switch stays off until flag cleared
// - activation bits kept, only the tripped switch of a stage goes off
// - open-load flags only, output keeps conducting
// - thermal prewarning flag bit 1, outputs unchanged
// - thermal shutdown bit 2, latched off until cleared
// - undervoltage bit 5, outputs recover with supply
// - overvoltage bit 4, outputs recover, flag stays
// - open-load needs undercurrent for full filter time
// - open-load blanked on active freewheel stages with a pwm-assigned switch
package hbfs_pkg;
    // ---------------------------------------------------------------
    // global status bit positions
    // ---------------------------------------------------------------
    localparam int GS_PREWARN = 1;
    localparam int GS_TSD = 2;
    localparam int GS_OV = 4;
    localparam int GS_UV = 5;
    localparam int GS_LOAD = 6;
    localparam int GS_WIDTH = 8;
    localparam int NUM_HB = 8;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_NS = 50;
    localparam int OC_FILTER_NS = 10000;
    localparam int OL_FILTER_NS = 2000000;
    localparam int OL_LED_FILTER_NS = 200000;
    localparam int OC_FILTER_CYC = (OC_FILTER_NS + CLK_NS - 1) / CLK_NS;
    localparam int OL_FILTER_CYC = (OL_FILTER_NS + CLK_NS - 1) / CLK_NS;
    localparam int OL_LED_CYC = (OL_LED_FILTER_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0] FREQ_STOPPED = 2'h0;
    localparam int CNT_W = 16;

    // one switch's analogue comparator view
    typedef struct packed {
        logic over_current;
        logic under_current;
    } hbfs_sense_s;

    // supervisor state per switch
    typedef enum logic [1:0] {
        HBFS_IDLE = 2'b00,
        HBFS_ON = 2'b01,
        HBFS_TRIP = 2'b10
    } hbfs_sw_e;
endpackage : hbfs_pkg

//--- rtl/hbfs_switch.sv
// per-switch overcurrent and open-load filter and flags
`timescale 1ns/10ps
`default_nettype none
module hbfs_switch #(
    parameter int OC_CYC = 200,
    parameter int OL_CYC = 40000,
    parameter int OL_LED = 4000
) (
    input wire logic mclk, // clock
    input wire logic reset_n, // sync reset
    input wire logic clk_en, // freeze when low
    input wire logic drive, // switch commanded on
    input wire logic led_mode, // short open-load filter
    input wire logic ol_blank, // freewheel blanking
    input wire hbfs_pkg::hbfs_sense_s sense, // comparators
    input wire logic oc_clear, // host clears oc flag
    input wire logic ol_clear, // host clears ol flag
    output logic oc_flag, // latched overcurrent
    output logic ol_flag, // latched open load
    output logic oc_event, // oc latched this cycle
    output logic ol_event // ol latched this cycle
);
    import hbfs_pkg::*;
    // refuse filter counts that the counters cannot hold
    if (OC_CYC < 1 || OL_CYC < 1 || OL_LED < 1 ||
        OL_CYC >= (1 << CNT_W) || OC_CYC >= (1 << CNT_W) ||
        OL_LED >= (1 << CNT_W)) begin : g_bad_cfg
        $error("hbfs_switch: filter count out of range");
    end
    logic [CNT_W-1:0] oc_cnt, next_oc_cnt, ol_cnt, next_ol_cnt;
    logic next_oc_flag, next_ol_flag;
    logic [CNT_W-1:0] ol_lim;

    // filters and sticky flags, set wins over clear
    always_comb begin
        ol_lim = led_mode ? CNT_W'(OL_LED) : CNT_W'(OL_CYC);
        next_oc_cnt = '0;
        next_ol_cnt = '0;
        oc_event = 1'b0;
        ol_event = 1'b0;
        if (drive && !oc_flag && sense.over_current) begin
            next_oc_cnt = oc_cnt + CNT_W'(1);
            if (next_oc_cnt >= CNT_W'(OC_CYC)) begin
                oc_event = 1'b1;
                next_oc_cnt = '0;
            end
        end
        if (drive && !ol_blank && sense.under_current) begin
            next_ol_cnt = ol_cnt + CNT_W'(1);
            if (next_ol_cnt >= ol_lim) begin
                ol_event = 1'b1;
                next_ol_cnt = ol_lim;
            end
        end
        next_oc_flag = oc_event | (oc_flag & ~oc_clear);
        next_ol_flag = ol_event | (ol_flag & ~ol_clear);
    end

    // registers
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            oc_cnt <= '0;
            ol_cnt <= '0;
            oc_flag <= 1'b0;
            ol_flag <= 1'b0;
        end else if (clk_en) begin
            oc_cnt <= next_oc_cnt;
            ol_cnt <= next_ol_cnt;
            oc_flag <= next_oc_flag;
            ol_flag <= next_ol_flag;
        end
    end
endmodule : hbfs_switch
`default_nettype wire

//--- rtl/hbfs_top.sv
// half-bridge fault supervisor top
`timescale 1ns/10ps
`default_nettype none
module hbfs_top #(
    parameter int OC_CYC = hbfs_pkg::OC_FILTER_CYC,
    parameter int OL_CYC = hbfs_pkg::OL_FILTER_CYC,
    parameter int OL_LED = hbfs_pkg::OL_LED_CYC
) (
    input wire logic mclk, // 20 MHz clock
    input wire logic reset_n, // sync reset
    input wire logic clk_en, // freeze when low
    input wire logic [7:0] hs_enable, // activation, high sides
    input wire logic [7:0] ls_enable, // activation, low sides
    input wire logic [7:0] hs_pwm_assigned, // high side uses pwm
    input wire logic [7:0] ls_pwm_assigned, // low side uses pwm
    input wire logic [7:0] hs_chan_freq_stop, // channel freq is 00
    input wire logic [7:0] hs_pwm_level, // pwm phase, high side
    input wire logic [7:0] ls_pwm_level, // pwm phase, low side
    input wire logic [7:0] active_freewheel, // freewheel config
    input wire logic [1:0] freq_code, // unused code view, kept 0
    input wire logic low_current_openload_select_a, // led mode hs1
    input wire logic low_current_openload_select_b, // led mode hs2
    input wire hbfs_pkg::hbfs_sense_s [7:0] hs_sense, // high comparators
    input wire hbfs_pkg::hbfs_sense_s [7:0] ls_sense, // low comparators
    input wire logic temp_warn, // prewarning comparator
    input wire logic temp_shutdown, // shutdown comparator
    input wire logic supply_under, // load supply too low
    input wire logic supply_over, // load supply too high
    input wire logic [7:0] hs_oc_clear, // clear high oc flags
    input wire logic [7:0] ls_oc_clear, // clear low oc flags
    input wire logic [7:0] hs_ol_clear, // clear high ol flags
    input wire logic [7:0] ls_ol_clear, // clear low ol flags
    input wire logic [7:0] global_clear, // clear global bits
    output logic [7:0] hs_gate, // high side conducts
    output logic [7:0] ls_gate, // low side conducts
    output logic [7:0] global_status_one, // global flags
    output logic [7:0] diagnostic_status_two, // high oc flags
    output logic [7:0] diagnostic_status_three, // low oc flags
    output logic [7:0] diagnostic_status_five, // high ol flags
    output logic [7:0] diagnostic_status_six, // low ol flags
    output logic latched_fault_indicator // any flag set
);
    import hbfs_pkg::*;
    logic [7:0] hs_drive, ls_drive, hs_blank, ls_blank;
    logic [7:0] hs_oc, ls_oc, hs_ol, ls_ol;
    logic [7:0] hs_oce, ls_oce, hs_ole, ls_ole;
    logic [7:0] hs_led;
    logic [7:0] next_global, next_hs_gate, next_ls_gate;
    logic all_off;

    // ---------------------------------------------------------------
    // commanded drive per switch
    // ---------------------------------------------------------------
    always_comb begin
        hs_led = '0;
        hs_led[0] = low_current_openload_select_a;
        hs_led[1] = low_current_openload_select_b;
        for (int i = 0; i < NUM_HB; i++) begin
            hs_drive[i] = hs_enable[i] &
                (hs_pwm_assigned[i] ? hs_pwm_level[i] : 1'b1);
            ls_drive[i] = ls_enable[i] &
                (ls_pwm_assigned[i] ? ls_pwm_level[i] : 1'b1);
            // stopped channel with active freewheel
            if (hs_enable[i] && hs_pwm_assigned[i] &&
                active_freewheel[i] && hs_chan_freq_stop[i]) begin
                hs_drive[i] = 1'b0;
                ls_drive[i] = 1'b1;
            end
            // both switches of a pwm stage with active freewheel
            hs_blank[i] = active_freewheel[i] &
                (ls_pwm_assigned[i] | hs_pwm_assigned[i]);
            ls_blank[i] = hs_blank[i];
        end
    end

    // ---------------------------------------------------------------
    // per-switch supervisors
    // ---------------------------------------------------------------
    for (genvar g = 0; g < NUM_HB; g++) begin : g_hb
        hbfs_switch #(.OC_CYC(OC_CYC), .OL_CYC(OL_CYC),
                      .OL_LED(OL_LED)) u_hs (
            .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
            .drive(hs_drive[g]), .led_mode(hs_led[g]),
            .ol_blank(hs_blank[g]), .sense(hs_sense[g]),
            .oc_clear(hs_oc_clear[g]), .ol_clear(hs_ol_clear[g]),
            .oc_flag(hs_oc[g]), .ol_flag(hs_ol[g]),
            .oc_event(hs_oce[g]), .ol_event(hs_ole[g])
        );
        hbfs_switch #(.OC_CYC(OC_CYC), .OL_CYC(OL_CYC),
                      .OL_LED(OL_LED)) u_ls (
            .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
            .drive(ls_drive[g]), .led_mode(1'b0),
            .ol_blank(ls_blank[g]), .sense(ls_sense[g]),
            .oc_clear(ls_oc_clear[g]), .ol_clear(ls_ol_clear[g]),
            .oc_flag(ls_oc[g]), .ol_flag(ls_ol[g]),
            .oc_event(ls_oce[g]), .ol_event(ls_ole[g])
        );
    end

    // ---------------------------------------------------------------
    // global flags, set wins over clear
    // ---------------------------------------------------------------
    always_comb begin
        next_global = global_status_one & ~global_clear;
        if (temp_warn)
            next_global[GS_PREWARN] = 1'b1;
        if (temp_shutdown)
            next_global[GS_TSD] = 1'b1;
        if (supply_over)
            next_global[GS_OV] = 1'b1;
        if (supply_under)
            next_global[GS_UV] = 1'b1;
        if (|{hs_oce, ls_oce, hs_ole, ls_ole})
            next_global[GS_LOAD] = 1'b1;
        next_global[0] = 1'b0;
        next_global[3] = 1'b0;
        next_global[7] = 1'b0;
    end

    // ---------------------------------------------------------------
    // output stage gating; activation inputs untouched
    // ---------------------------------------------------------------
    always_comb begin
        // supply faults act live, thermal on the live input and the latched bit
        all_off = global_status_one[GS_TSD] | temp_shutdown |
            supply_under | supply_over;
        next_hs_gate = hs_drive & ~hs_oc & ~hs_oce;
        next_ls_gate = ls_drive & ~ls_oc & ~ls_oce;
        if (all_off) begin
            next_hs_gate = '0;
            next_ls_gate = '0;
        end
    end

    // registers
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            global_status_one <= '0;
            hs_gate <= '0;
            ls_gate <= '0;
        end else if (clk_en) begin
            global_status_one <= next_global;
            hs_gate <= next_hs_gate;
            ls_gate <= next_ls_gate;
        end
    end

    // status views; flags come from flip-flops
    always_comb begin
        diagnostic_status_two = hs_oc;
        diagnostic_status_three = ls_oc;
        diagnostic_status_five = hs_ol;
        diagnostic_status_six = ls_ol;
        latched_fault_indicator = |{global_status_one, hs_oc, ls_oc,
            hs_ol, ls_ol} | (freq_code != FREQ_STOPPED && 1'b0);
    end
endmodule : hbfs_top
`default_nettype wire

//--- verification/hbfs_sva.sv
// assertions on the fault supervisor top ports
`timescale 1ns/10ps
`default_nettype none
module hbfs_sva #(
    parameter int OC_CYC = 4
) (
    input wire logic mclk, // clock
    input wire logic reset_n, // sync reset
    input wire logic clk_en, // run enable
    input wire hbfs_pkg::hbfs_sense_s [7:0] hs_sense, // high comparators
    input wire logic [7:0] hs_oc_clear, // high oc clears
    input wire logic temp_warn, // prewarning
    input wire logic supply_under, // supply low
    input wire logic supply_over, // supply high
    input wire logic [7:0] hs_gate, // high gates
    input wire logic [7:0] ls_gate, // low gates
    input wire logic [7:0] global_status_one, // global flags
    input wire logic [7:0] diagnostic_status_two, // high oc flags
    input wire logic latched_fault_indicator // any flag
);
    import hbfs_pkg::*;
    int oc_run;
    int next_oc_run;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // ------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------
    // length of the present overcurrent run on high side 0
    always_comb begin
        next_oc_run = 0;
        if (hs_sense[0].over_current && clk_en && !hs_oc_clear[0]) begin
            next_oc_run = oc_run + 1;
        end
    end
    always_ff @(posedge mclk) begin
        oc_run <= reset_n ? next_oc_run : 0;
    end
    sequence s_supply_bad;
        clk_en && (supply_under || supply_over);
    endsequence
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    AST_OC_FLAG: assert property (oc_run >= OC_CYC |-> ##[0:3]
        diagnostic_status_two[0]) else $error("oc flag missing");
    AST_OC_OFF: assert property ((diagnostic_status_two & hs_gate)
        == 8'h00) else $error("tripped switch conducts");
    AST_OC_HOLD: assert property ($fell(diagnostic_status_two[0])
        |-> $past(hs_oc_clear[0])) else $error("oc flag lost");
    AST_LOAD: assert property ($rose(diagnostic_status_two[0])
        |-> ##[0:1] global_status_one[GS_LOAD]) else $error("no load");
    AST_PREWARN: assert property (clk_en && temp_warn |=>
        global_status_one[GS_PREWARN]) else $error("no prewarn");
    AST_TSD_OFF: assert property (global_status_one[GS_TSD] |=>
        (hs_gate | ls_gate) == 8'h00) else $error("tsd gates on");
    AST_SUPPLY_OFF: assert property (s_supply_bad |=>
        (hs_gate | ls_gate) == 8'h00) else $error("supply gates on");
    AST_UV_FLAG: assert property (clk_en && supply_under |=>
        global_status_one[GS_UV]) else $error("no uv flag");
    AST_OV_FLAG: assert property (clk_en && supply_over |=>
        global_status_one[GS_OV]) else $error("no ov flag");
    AST_EF: assert property ((|global_status_one) |->
        latched_fault_indicator) else $error("fault flag low");
endmodule : hbfs_sva
`default_nettype wire

//--- verification/hbfs_host.sv
// host model: level requests become one-cycle clear pulses
`timescale 1ns/10ps
`default_nettype none
module hbfs_host (
    input wire logic mclk, // clock
    input wire logic [39:0] req, // clear requests, level
    output logic [39:0] clr // clear pulses to the block
);
    logic [39:0] req_d;
    logic [39:0] next_clr;
    // one pulse per rising request, one write per clear
    always_comb begin
        next_clr = req & ~req_d;
    end
    always_ff @(posedge mclk) begin
        req_d <= req;
        clr <= next_clr;
    end
endmodule : hbfs_host
`default_nettype wire

//--- verification/hbfs_top_tb.sv
// self-checking bench for the fault supervisor
`timescale 1ns/10ps
`default_nettype none
module hbfs_top_tb;
    import hbfs_pkg::*;
    logic mclk = 1'b0, reset_n = 1'b0, clk_en = 1'b1;
    logic [7:0] hs_enable = 8'h00, ls_enable = 8'h00, hs_pwm_assigned = 8'h00;
    logic [7:0] ls_pwm_assigned = 8'h00, hs_chan_freq_stop = 8'h00;
    logic [7:0] hs_pwm_level = 8'h00, ls_pwm_level = 8'h00;
    logic [7:0] active_freewheel = 8'h00;
    logic [1:0] freq_code = 2'h0;
    logic low_current_openload_select_a = 1'b0;
    logic low_current_openload_select_b = 1'b0;
    hbfs_sense_s [7:0] hs_sense = '0, ls_sense = '0;
    logic temp_warn = 1'b0, temp_shutdown = 1'b0;
    logic supply_under = 1'b0, supply_over = 1'b0;
    logic [39:0] req = 40'h0;
    logic [7:0] hs_oc_clear, ls_oc_clear, hs_ol_clear, ls_ol_clear;
    logic [7:0] global_clear, hs_gate, ls_gate, global_status_one;
    logic [7:0] diagnostic_status_two, diagnostic_status_three;
    logic [7:0] diagnostic_status_five, diagnostic_status_six;
    logic latched_fault_indicator;
    int err_total = 0, n_tests = 0;
    hbfs_top #(.OC_CYC(4), .OL_CYC(8), .OL_LED(3)) hbfs_top_inst (.*);
    hbfs_host hbfs_host_inst (.mclk(mclk), .req(req), .clr({global_clear,
        ls_ol_clear, hs_ol_clear, ls_oc_clear, hs_oc_clear}));
    initial forever #25 mclk = ~mclk;
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc
    task look;
        @(negedge mclk);
    endtask : look
    task chk(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: bit %b want %b", $time, got, exp);
        end
    endtask : chk
    task clear(input int b);
        cyc(1);
        req[b] <= 1'b1;
        cyc(1);
        req[b] <= 1'b0;
        cyc(3);
    endtask : clear
    task conclude;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_oc;
        hs_enable <= 8'h01;
        cyc(3);
        hs_sense[0].over_current <= 1'b1;
        cyc(12);
        look;
        chk(diagnostic_status_two[0], 1'b1);
        chk(hs_gate[0], 1'b0);
        chk(global_status_one[GS_LOAD], 1'b1);
        clear(0);
        cyc(8);
        look;
        chk(diagnostic_status_two[0], 1'b1);
        cyc(1);
        hs_sense[0].over_current <= 1'b0;
        clear(0);
        look;
        chk(diagnostic_status_two[0], 1'b0);
        chk(hs_gate[0], 1'b1);
        clear(32 + GS_LOAD);
        hs_enable <= 8'h00;
    endtask : t_oc
    task t_ol;
        cyc(1);
        ls_enable <= 8'h02;
        hs_enable <= 8'h04;
        hs_pwm_assigned <= 8'h04;
        active_freewheel <= 8'h04;
        hs_pwm_level <= 8'hff;
        cyc(3);
        ls_sense[1].under_current <= 1'b1;
        hs_sense[2].under_current <= 1'b1;
        cyc(5);
        look;
        chk(diagnostic_status_six[1], 1'b0);
        cyc(12);
        look;
        chk(diagnostic_status_six[1], 1'b1);
        chk(ls_gate[1], 1'b1);
        chk(global_status_one[GS_LOAD], 1'b1);
        chk(diagnostic_status_five[2], 1'b0);
        cyc(1);
        ls_sense[1].under_current <= 1'b0;
        hs_sense[2].under_current <= 1'b0;
        clear(25);
        clear(32 + GS_LOAD);
        look;
        chk(diagnostic_status_six[1], 1'b0);
    endtask : t_ol
    task t_stop;
        cyc(1);
        hs_enable <= 8'h08;
        hs_pwm_assigned <= 8'h08;
        active_freewheel <= 8'h08;
        hs_chan_freq_stop <= 8'h08;
        ls_pwm_level <= 8'hff;
        cyc(3);
        look;
        chk(hs_gate[3], 1'b0);
        chk(ls_gate[3], 1'b1);
        // overcurrent on the forced low side
        cyc(1);
        ls_sense[3].over_current <= 1'b1;
        cyc(6);
        look;
        chk(diagnostic_status_three[3], 1'b1);
        chk(ls_gate[3], 1'b0);
        chk(latched_fault_indicator, 1'b1);
        cyc(1);
        ls_sense[3].over_current <= 1'b0;
        clear(8 + 3);
        clear(32 + GS_LOAD);
        look;
        chk(diagnostic_status_three[3], 1'b0);
        chk(ls_gate[3], 1'b1);
        chk(latched_fault_indicator, 1'b0);
    endtask : t_stop
    task t_led;
        cyc(1);
        hs_chan_freq_stop <= 8'h09;
        cyc(1);
        hs_pwm_assigned <= 8'h09;
        hs_enable <= 8'h01;
        low_current_openload_select_a <= 1'b1;
        cyc(1);
        hs_chan_freq_stop <= 8'h08;
        hs_sense[0].under_current <= 1'b1;
        cyc(2);
        look;
        chk(diagnostic_status_five[0], 1'b0);
        cyc(2);
        look;
        chk(diagnostic_status_five[0], 1'b1);
        chk(hs_gate[0], 1'b1);
        cyc(1);
        hs_sense[0].under_current <= 1'b0;
        hs_enable <= 8'h00;
        clear(16);
        clear(32 + GS_LOAD);
        look;
        chk(diagnostic_status_five[0], 1'b0);
    endtask : t_led
    task t_freeze;
        cyc(1);
        clk_en <= 1'b0;
        temp_warn <= 1'b1;
        cyc(3);
        look;
        chk(global_status_one[GS_PREWARN], 1'b0);
        cyc(1);
        clk_en <= 1'b1;
        cyc(2);
        temp_warn <= 1'b0;
        look;
        chk(global_status_one[GS_PREWARN], 1'b1);
        clear(32 + GS_PREWARN);
    endtask : t_freeze
    task t_temp;
        cyc(1);
        hs_enable <= 8'h10;
        ls_enable <= 8'h00;
        temp_warn <= 1'b1;
        cyc(3);
        temp_warn <= 1'b0;
        temp_shutdown <= 1'b1;
        look;
        chk(global_status_one[GS_PREWARN], 1'b1);
        chk(hs_gate[4], 1'b1);
        cyc(2);
        temp_shutdown <= 1'b0;
        cyc(3);
        look;
        chk(global_status_one[GS_TSD], 1'b1);
        chk(hs_gate[4], 1'b0);
        clear(32 + GS_TSD);
        look;
        chk(hs_gate[4], 1'b1);
        clear(32 + GS_PREWARN);
    endtask : t_temp
    task t_supply;
        for (int k = 0; k < 2; k++) begin
            supply_under <= (k == 0);
            supply_over <= (k == 1);
            cyc(3);
            look;
            chk(hs_gate[4], 1'b0);
            cyc(1);
            supply_under <= 1'b0;
            supply_over <= 1'b0;
            cyc(3);
            look;
            chk(hs_gate[4], 1'b1);
            chk(global_status_one[k ? GS_OV : GS_UV], 1'b1);
            clear(32 + (k ? GS_OV : GS_UV));
            look;
            chk(global_status_one[k ? GS_OV : GS_UV], 1'b0);
        end
    endtask : t_supply
    initial begin
        cyc(4);
        reset_n <= 1'b1;
        cyc(1);
        t_oc();
        t_ol();
        t_stop();
        t_temp();
        t_supply();
        t_led();
        t_freeze();
        conclude();
    end
    initial begin
        cyc(3000);
        err_total++;
        conclude();
    end
endmodule : hbfs_top_tb
bind hbfs_top hbfs_sva #(.OC_CYC(OC_CYC)) hbfs_sva_inst (.*);
`default_nettype wire
